// ---- src/datacomm_interrupt_cause_mask.sv ----
// Datacomm interrupt cause/mask block with AXI4-Lite register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module datacomm_interrupt_cause_mask (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Cause events, one-cycle pulses, meaning per protocol mode
    input wire logic [dc_intr_pkg::cause_width-1:0] cause_event,
    // Receive queue state
    input wire logic rxq_has_data,
    input wire logic rxq_has_ctrl,
    input wire logic rxq_full,
    input wire logic rxq_push,
    // Link side
    output logic remote_hold_off,
    // Host interrupt
    output logic irq
);
    import dc_intr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] valid_causes(input logic mode);
        valid_causes = (mode == mode_link) ? link_valid_causes : async_valid_causes;
    endfunction : valid_causes

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] cause;
    logic [7:0] mask;
    logic mode;
    logic handshake_en;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic [7:0] next_cause;
    logic [7:0] next_mask;
    logic next_mode;
    logic next_handshake_en;
    logic next_aw_held;
    logic [7:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_irq;
    logic next_awready;
    logic next_wready;

    logic [1:0] rxq_status;
    logic overflow;
    logic do_write;
    logic do_read;
    logic cause_read;
    logic [7:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // Receive queue flow

    dc_rxq_flow u_rxq_flow (
        .aclk(aclk),
        .aresetn(aresetn),
        .handshake_en(handshake_en),
        .rxq_has_data(rxq_has_data),
        .rxq_has_ctrl(rxq_has_ctrl),
        .rxq_full(rxq_full),
        .rxq_push(rxq_push),
        .rxq_status(rxq_status),
        .hold_off(remote_hold_off),
        .overflow(overflow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and cause logic

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_mask = mask;
        next_mode = mode;
        next_handshake_en = handshake_en;

        // Address and data may arrive in either order; each is held once taken
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end

        do_write = aw_held && w_held && !s_axi_bvalid;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = resp_okay;
            case (aw_addr)
                ctrl_off: begin
                    if (w_strb[0]) begin
                        next_mode = w_data[ctrl_mode_bit];
                        next_handshake_en = w_data[ctrl_hs_bit];
                    end
                end
                mask_off: begin
                    // Mask is the sum of wanted cause weights
                    if (w_strb[0]) begin
                        next_mask = w_data[7:0];
                    end
                end
                cause_off, rxq_off, raw_off: begin
                    // Read-only words: write ignored
                end
                default: begin
                    next_bresp = resp_slverr;
                end
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        // Reads: arready pulses for one cycle, data follows next cycle
        do_read = s_axi_arvalid && s_axi_arready;
        cause_read = 1'b0;
        if (!s_axi_arready && !s_axi_rvalid && s_axi_arvalid) begin
            next_arready = 1'b1;
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = resp_okay;
            case (s_axi_araddr)
                ctrl_off: next_rdata = {30'h00000000, handshake_en, mode};
                cause_off: begin
                    next_rdata = zext8(cause);
                    cause_read = 1'b1;
                end
                mask_off: next_rdata = zext8(mask);
                rxq_off: next_rdata = {30'h00000000, rxq_status};
                raw_off: next_rdata = zext8(cause & mask);
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = resp_slverr;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end

        // Overflow without handshaking reports as a character-mode error
        events = cause_event;
        if (mode == mode_async) begin
            events[bit_error] = cause_event[bit_error] | overflow;
        end
        events = events & valid_causes(mode);
        // Read clears, but an event in the same cycle still sets
        next_cause = (cause_read ? 8'h00 : cause) | events;
        // Only unmasked causes reach the host
        next_irq = |(next_cause & next_mask);

        next_awready = !aw_held && !s_axi_awready && s_axi_awvalid && !next_aw_held;
        next_wready = !w_held && !s_axi_wready && s_axi_wvalid && !next_w_held;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause <= cause_reset;
            mask <= mask_reset;
            mode <= ctrl_mode_reset;
            handshake_en <= ctrl_hs_reset;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= resp_okay;
            irq <= 1'b0;
        end else begin
            cause <= next_cause;
            mask <= next_mask;
            mode <= next_mode;
            handshake_en <= next_handshake_en;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            irq <= next_irq;
        end
    end

endmodule : datacomm_interrupt_cause_mask

// ---- pkg/dc_intr_pkg.sv ----
// Package: register map, cause bit layout and constants for the datacomm interrupt block
package dc_intr_pkg;

    // Register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] cause_off = 8'h04;
    localparam logic [7:0] mask_off = 8'h08;
    localparam logic [7:0] rxq_off = 8'h0c;
    localparam logic [7:0] raw_off = 8'h10;

    localparam int cause_width = 8;

    // Cause bit positions shared by both protocol modes
    localparam int bit_rx_data = 0;
    localparam int bit_prompt_or_sent = 1;
    localparam int bit_error = 2;
    localparam int bit_modem_change = 3;
    localparam int bit_no_activity = 4;
    localparam int bit_lost_carrier = 5;
    // Character mode only
    localparam int bit_eol = 6;
    localparam int bit_break = 7;

    // Causes that exist in block-link mode and in character mode
    localparam logic [7:0] link_valid_causes = 8'h3f;
    localparam logic [7:0] async_valid_causes = 8'hff;

    // Reset values
    localparam logic [7:0] cause_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic ctrl_mode_reset = 1'b0;
    localparam logic ctrl_hs_reset = 1'b0;

    // Control register fields
    localparam int ctrl_mode_bit = 0;
    localparam int ctrl_hs_bit = 1;

    // Receive queue status codes
    localparam logic [1:0] rxq_empty = 2'h0;
    localparam logic [1:0] rxq_data = 2'h1;
    localparam logic [1:0] rxq_ctrl = 2'h2;
    localparam logic [1:0] rxq_both = 2'h3;

    // AXI responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [0:0] {
        mode_async = 1'b0,
        mode_link = 1'b1
    } proto_mode_e;

endpackage : dc_intr_pkg

// ---- src/dc_rxq_flow.sv ----
// Receive queue occupancy status and remote hold-off logic
`timescale 1ns/1ps
module dc_rxq_flow (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration
    input wire logic handshake_en,
    // Queue state from the datapath
    input wire logic rxq_has_data,
    input wire logic rxq_has_ctrl,
    input wire logic rxq_full,
    input wire logic rxq_push,
    // Results
    output logic [1:0] rxq_status,
    output logic hold_off,
    output logic overflow
);
    import dc_intr_pkg::*;

    logic [1:0] next_rxq_status;
    logic next_hold_off;
    logic next_overflow;

    always_comb begin
        next_rxq_status = {rxq_has_ctrl, rxq_has_data};
        // Hold the remote off while full only when handshaking is on
        next_hold_off = handshake_en & rxq_full;
        // Without handshaking a push into a full queue is lost data
        next_overflow = ~handshake_en & rxq_full & rxq_push;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxq_status <= rxq_empty;
            hold_off <= 1'b0;
            overflow <= 1'b0;
        end else begin
            rxq_status <= next_rxq_status;
            hold_off <= next_hold_off;
            overflow <= next_overflow;
        end
    end

endmodule : dc_rxq_flow

// ---- verification/dc_intr_sva.sv ----
// Port-level assertions for the datacomm interrupt cause/mask block
`timescale 1ns/1ps
module dc_intr_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    // Events and results
    input wire logic [7:0] cause_event,
    input wire logic rxq_full, rxq_push, remote_hold_off, irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Mask writes may move irq too, so a write response counts as a cause
    irq_rise_a: assert property ($rose(irq) |->
        (|$past(cause_event)) || $past(rxq_push, 2) || $past(rxq_push, 3)
        || s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq rose with no event");
    irq_fall_a: assert property ($fell(irq) |->
        $past(s_axi_arready) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq dropped with no acknowledge");
    hold_clear_a: assert property (!rxq_full |=> !remote_hold_off)
        else $error("hold-off without full queue");
    hold_rise_a: assert property ($rose(remote_hold_off) |-> $past(rxq_full))
        else $error("hold-off rose early");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |->
        ##[1:4] s_axi_bvalid) else $error("write response late");
    wr_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than a cycle");
endmodule : dc_intr_sva

bind datacomm_interrupt_cause_mask dc_intr_sva chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_rdata, .cause_event, .rxq_full, .rxq_push, .remote_hold_off, .irq
);

// ---- verification/dc_host_model.sv ----
// Host processor model: AXI4-Lite master for register cycles
`timescale 1ns/1ps
module dc_host_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] s_axi_awaddr,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
    input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    // Read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid, s_axi_rready,
    input wire logic s_axi_arready, s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    int hung = 0;
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bready and rready stand from the request on; the answer is taken at the edge that sees it
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) hung++;
    endtask : wr
    // A cause read is the acknowledge of the interrupt
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) hung++;
    endtask : rd
endmodule : dc_host_model

// ---- verification/datacomm_interrupt_cause_mask_bench.sv ----
// Self-checking bench for the datacomm interrupt cause/mask block
`timescale 1ns/1ps
module datacomm_interrupt_cause_mask_bench;
    import dc_intr_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic remote_hold_off, irq;
    logic [7:0] cause_event = 8'h00;
    logic rxq_has_data = 1'b0, rxq_has_ctrl = 1'b0, rxq_full = 1'b0, rxq_push = 1'b0;
    int err_total = 0;
    int tests_run = 0;
    always #2.5 aclk = ~aclk;
    datacomm_interrupt_cause_mask dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cause_event, .rxq_has_data,
        .rxq_has_ctrl, .rxq_full, .rxq_push, .remote_hold_off, .irq
    );
    dc_host_model host_u (
        .aclk, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid, .s_axi_wvalid,
        .s_axi_bready, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_rready, .s_axi_arready, .s_axi_rvalid,
        .s_axi_rdata, .s_axi_rresp
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        err_total += host_u.hung;
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        host_u.wr(a, d, r);
        if (host_u.hung != 0) conclude();
        check(r, resp_okay);
        #1;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        host_u.rd(a, d, r);
        if (host_u.hung != 0) conclude();
        check(d, exp);
        check(r, resp_okay);
        #1;
    endtask : reg_rd
    // Event lasts one cycle; sampled once the setting edge has landed
    task automatic pulse(input logic [7:0] v);
        @(posedge aclk);
        cause_event <= v;
        @(posedge aclk);
        cause_event <= 8'h00;
        #1;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        reg_rd(cause_off, 32'h0);
        reg_rd(mask_off, 32'h0);
        check(irq, 32'h0);
    endtask : t_reset
    task automatic t_async_causes();
        logic [7:0] m;
        m = 8'h01 + 8'h08 + 8'h20;
        reg_wr(mask_off, m);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            check(irq, 32'(m[i]));
            reg_rd(cause_off, 32'h1 << i);
            check(irq, 32'h0);
        end
    endtask : t_async_causes
    task automatic t_link_mode();
        reg_wr(ctrl_off, 8'h01);
        reg_rd(ctrl_off, 32'h1);
        reg_wr(mask_off, 8'hff);
        pulse(8'hff);
        check(irq, 32'h1);
        reg_rd(cause_off, 32'h3f);
        reg_wr(ctrl_off, 8'h00);
        pulse(8'hc0);
        reg_rd(cause_off, 32'hc0);
    endtask : t_link_mode
    task automatic t_masked();
        reg_wr(mask_off, 8'h06);
        pulse(8'h0f);
        check(irq, 32'h1);
        reg_rd(raw_off, 32'h06);
        reg_rd(cause_off, 32'h0f);
        check(irq, 32'h0);
    endtask : t_masked
    task automatic t_rxq();
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            {rxq_has_ctrl, rxq_has_data} <= 2'(i);
            reg_rd(rxq_off, 32'(i));
        end
    endtask : t_rxq
    task automatic t_flow();
        reg_wr(ctrl_off, 8'h02);
        reg_rd(ctrl_off, 32'h2);
        // A push into a full queue with handshaking on must not be lost data
        @(posedge aclk);
        rxq_full <= 1'b1;
        rxq_push <= 1'b1;
        @(posedge aclk);
        rxq_push <= 1'b0;
        @(posedge aclk);
        #1;
        check(remote_hold_off, 32'h1);
        reg_rd(cause_off, 32'h0);
        reg_wr(ctrl_off, 8'h00);
        @(posedge aclk);
        rxq_push <= 1'b1;
        @(posedge aclk);
        rxq_push <= 1'b0;
        rxq_full <= 1'b0;
        #1;
        check(remote_hold_off, 32'h0);
        repeat (3) @(posedge aclk);
        reg_rd(cause_off, 32'h04);
    endtask : t_flow
    task automatic t_bad_addr();
        logic [31:0] d;
        logic [1:0] r;
        host_u.rd(8'h20, d, r);
        check(r, resp_slverr);
        check(d, 32'h0);
        host_u.wr(8'h20, 8'h00, r);
        check(r, resp_slverr);
    endtask : t_bad_addr
    // Reset in mid-run drops a pending request and the mask
    task automatic t_mid_reset();
        reg_wr(mask_off, 8'h01);
        pulse(8'h01);
        check(irq, 32'h1);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check(irq, 32'h0);
        reg_rd(cause_off, 32'h0);
        reg_rd(mask_off, 32'h0);
    endtask : t_mid_reset
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_async_causes();
        t_link_mode();
        t_masked();
        t_rxq();
        t_flow();
        t_bad_addr();
        t_mid_reset();
        conclude();
    end
endmodule : datacomm_interrupt_cause_mask_bench
